// *** core/bia_top.sv ***
// interrupter and interrupt handler for the backplane acknowledge cycle
//
// Overview of operation
// - idle interrupter with irq_wanted drives its configured request line low, unless it answers (steals) an acknowledge already addressed to it.
// - acknowledge needs strobe low, acknowledge code, own level, daisy input low.
// - on acknowledge with data strobe 0 low, drive status/ID byte.
// - status/ID byte valid at least 30 ns before data acknowledge goes low.
// - after data acknowledge asserts, release request line; acked may rise either side.
// - with acknowledge asserted and irq_wanted high, drive bus_irq_acked high.
// - after strobe rises, release data acknowledge once data off and 30 ns passed.
// - after data acknowledge release and irq_wanted low, drop acked, go idle.
// - idle interrupter without own request passes daisy low onward.
// - irq_wanted rising before passing lets interrupter answer same-level acknowledge.
// - answering interrupter never passes the daisy low downstream.
// - passed daisy output returns high within 50 ns of strobe rising.
// - prioritizer picks highest pending enabled level; single level is its own top.
// - bus wanted only when selected level exceeds mask level.
// - prioritizer hands the 3-bit level to the address driver.
// - on grant drive acknowledge code and level, then strobe low, then read.
// - data controller drives write high for read, then data strobe 0 low.
// - on data acknowledge latch byte, release write and data strobe, and report, all on one edge.
// - address lines drop on data acknowledge; strobe held until release reported.
// - fixed acknowledge code 27 hex, active low, driven and matched.
// - level appears active low on three lowest address lines, levels one to seven.
// - address and modifier lines stable 30 ns before strobe goes low.
`timescale 1ns/100ps
module bia_top
	import bia_pkg::*;
(
	input  wire logic       clk,
	input  wire logic       resetn,
	// on-board device side of the interrupter
	input  wire logic       irq_wanted,
	output logic            bus_irq_acked,
	input  wire logic [2:0] irq_level,
	input  wire logic [7:0] status_id,
	// on-board side of the handler
	input  wire logic [7:1] level_enable,
	input  wire logic [2:0] mask_level,
	output logic            bus_wanted,
	input  wire logic       bus_granted,
	output logic [2:0]      ack_level,
	output logic [7:0]      status_read,
	output logic            status_valid,
	output logic            status_error,
	// interrupt request lines
	input  wire logic [7:1] irq_n_i,
	output logic [7:1]      irq_n_o,
	output logic [7:1]      irq_n_oe,
	// daisy chain
	input  wire logic       ackin_n,
	output logic            ackout_n,
	// address strobe and address
	input  wire logic       as_n_i,
	output logic            as_n_o,
	output logic            as_n_oe,
	input  wire logic [7:0] am_n_i,
	output logic [7:0]      am_n_o,
	output logic            am_n_oe,
	input  wire logic [2:0] addr_n_i,
	output logic [2:0]      addr_n_o,
	output logic            addr_n_oe,
	// data strobe, write, data and handshake
	input  wire logic       ds0_n_i,
	output logic            ds0_n_o,
	output logic            ds0_n_oe,
	output logic            write_n_o,
	output logic            write_n_oe,
	input  wire logic [7:0] data_n_i,
	output logic [7:0]      data_n_o,
	output logic            data_n_oe,
	input  wire logic       dtack_n_i,
	output logic            dtack_n_o,
	output logic            dtack_n_oe,
	input  wire logic       berr_n_i
);

	// ----------------------------------------
	// reset release
	// ----------------------------------------
	logic rst_meta;
	logic rst_n;

	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			rst_meta <= 1'b0;
			rst_n    <= 1'b0;
		end else begin
			rst_meta <= 1'b1;
			rst_n    <= rst_meta;
		end
	end

	// ----------------------------------------
	// shared decode
	// ----------------------------------------
	function automatic logic [7:1] level_onehot(input logic [2:0] lv);
		logic [7:1] oh;
		oh = 7'h00;
		for (int i = 1; i <= 7; i++) begin
			if (lv == 3'(i)) begin
				oh[i] = 1'b1;
			end
		end
		return oh;
	endfunction

	function automatic logic [2:0] next_count(input logic [2:0] c);
		return (c == 3'h7) ? c : 3'(c + CNT_ONE);
	endfunction

	wire logic iack_code  = (am_n_i == ~BIA_IACK_CODE);
	wire logic level_hit  = (addr_n_i == ~irq_level);
	wire logic ack_cycle  = !as_n_i && iack_code && level_hit;
	wire logic ack_for_us = ack_cycle && !ackin_n;
	wire logic bus_quiet  = dtack_n_i && berr_n_i;

	// ----------------------------------------
	// interrupter
	// ----------------------------------------
	bia_int_state_t int_state;
	logic [2:0]     int_cnt;
	logic           irq_drive;

	// stealing is allowed only from idle, so a passed low is never also answered
	wire logic steal   = irq_wanted && ack_for_us;
	// passing waits for the strobe, so the rise that ends it belongs to this cycle
	wire logic pass_ok = !ackin_n && !as_n_i && !steal;

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			int_state     <= INT_IDLE;
			int_cnt       <= CNT_ZERO;
			irq_drive     <= 1'b0;
			ackout_n      <= 1'b1;
			bus_irq_acked <= 1'b0;
			data_n_oe     <= 1'b0;
			data_n_o      <= 8'hff;
			dtack_n_oe    <= 1'b0;
		end else begin
			case (int_state)
				INT_IDLE: begin
					if (steal) begin
						int_state <= INT_REQ;
					end else if (irq_wanted) begin
						irq_drive <= 1'b1;
						int_state <= INT_REQ;
					end else if (pass_ok) begin
						ackout_n  <= 1'b0;
						int_state <= INT_PASS;
					end
				end
				INT_PASS: begin
					int_cnt <= next_count(int_cnt);
					// one cycle after strobe rises just meets the 50 ns limit
					if (as_n_i || int_cnt >= ACKOUT_MAX_CYC && as_n_i) begin
						ackout_n  <= 1'b1;
						int_cnt   <= CNT_ZERO;
						int_state <= irq_drive ? INT_REQ : INT_IDLE;
					end
				end
				INT_REQ: begin
					if (ack_for_us && !ds0_n_i) begin
						data_n_o  <= ~status_id;
						data_n_oe <= 1'b1;
						int_cnt   <= CNT_ONE;
						int_state <= INT_DATA;
					end else if (pass_ok && !level_hit) begin
						// a request at another level must not block the chain
						ackout_n  <= 1'b0;
						int_state <= INT_PASS;
					end
				end
				INT_DATA: begin
					int_cnt <= next_count(int_cnt);
					if (int_cnt >= DATA_SETUP_CYC) begin
						dtack_n_oe <= 1'b1;
						int_cnt    <= CNT_ZERO;
						int_state  <= INT_ACK;
					end
				end
				INT_ACK: begin
					irq_drive     <= 1'b0;
					bus_irq_acked <= irq_wanted;
					int_cnt       <= CNT_ONE;
					int_state     <= INT_WAIT;
				end
				INT_WAIT: begin
					int_cnt <= next_count(int_cnt);
					if (irq_wanted) begin
						bus_irq_acked <= 1'b1;
					end
					if (as_n_i) begin
						data_n_oe <= 1'b0;
					end
					if (as_n_i && !data_n_oe && int_cnt > IRQ_REL_CYC) begin
						dtack_n_oe <= 1'b0;
						int_state  <= INT_DONE;
					end
				end
				INT_DONE: begin
					// leaving needs irq_wanted low, which the device keeps until acked drops
					if (!irq_wanted) begin
						bus_irq_acked <= 1'b0;
						int_cnt       <= CNT_ZERO;
						int_state     <= INT_IDLE;
					end
				end
				default: begin
					int_state <= INT_IDLE;
				end
			endcase
		end
	end

	wire logic [7:1] irq_lines = irq_drive ? level_onehot(irq_level) : 7'h00;

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			irq_n_oe <= 7'h00;
		end else begin
			irq_n_oe <= irq_lines;
		end
	end

	assign irq_n_o   = 7'h00;
	assign dtack_n_o = 1'b0;

	// ----------------------------------------
	// handler
	// ----------------------------------------
	logic       pri_pending;
	logic [2:0] pri_level;

	bia_prioritizer u_prioritizer (
		.clk          (clk),
		.rst_n        (rst_n),
		.irq_n_i      (irq_n_i),
		.level_enable (level_enable),
		.mask_level   (mask_level),
		.pending      (pri_pending),
		.level        (pri_level)
	);

	bia_hnd_state_t hnd_state;
	logic [2:0]     hnd_cnt;

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			hnd_state    <= HND_IDLE;
			hnd_cnt      <= CNT_ZERO;
			bus_wanted   <= 1'b0;
			ack_level    <= BIA_LEVEL_NONE;
			am_n_o       <= 8'hff;
			am_n_oe      <= 1'b0;
			addr_n_o     <= 3'h7;
			addr_n_oe    <= 1'b0;
			as_n_o       <= 1'b1;
			as_n_oe      <= 1'b0;
			write_n_o    <= 1'b1;
			write_n_oe   <= 1'b0;
			ds0_n_o      <= 1'b1;
			ds0_n_oe     <= 1'b0;
			status_read  <= BIA_STATUS_RST;
			status_valid <= 1'b0;
			status_error <= 1'b0;
		end else begin
			status_valid <= 1'b0;
			status_error <= 1'b0;
			case (hnd_state)
				HND_IDLE: begin
					if (pri_pending) begin
						bus_wanted <= 1'b1;
						ack_level  <= pri_level;
						hnd_state  <= HND_REQ;
					end
				end
				HND_REQ: begin
					// the previous master must have let the strobe go first
					if (bus_granted && as_n_i) begin
						am_n_o     <= ~BIA_IACK_CODE;
						am_n_oe    <= 1'b1;
						addr_n_o   <= ~ack_level;
						addr_n_oe  <= 1'b1;
						as_n_o     <= 1'b1;
						as_n_oe    <= 1'b1;
						hnd_cnt    <= CNT_ONE;
						hnd_state  <= HND_SETUP;
					end
				end
				HND_SETUP: begin
					hnd_cnt <= next_count(hnd_cnt);
					if (hnd_cnt >= ADDR_SETUP_CYC) begin
						as_n_o    <= 1'b0;
						hnd_state <= HND_ASL;
					end
					if (bus_quiet) begin
						write_n_o  <= 1'b1;
						write_n_oe <= 1'b1;
						ds0_n_o    <= 1'b1;
						ds0_n_oe   <= 1'b1;
					end
				end
				HND_ASL: begin
					// waiting for the old slave to let go avoids data contention
					if (bus_quiet && write_n_oe) begin
						ds0_n_o   <= 1'b0;
						hnd_state <= HND_READ;
					end else if (bus_quiet) begin
						write_n_o  <= 1'b1;
						write_n_oe <= 1'b1;
						ds0_n_oe   <= 1'b1;
					end
				end
				HND_READ: begin
					if (!dtack_n_i || !berr_n_i) begin
						status_read  <= !dtack_n_i ? ~data_n_i : status_read;
						status_valid <= !dtack_n_i;
						status_error <= dtack_n_i;
						am_n_oe      <= 1'b0;
						addr_n_oe    <= 1'b0;
						write_n_oe   <= 1'b0;
						ds0_n_oe     <= 1'b0;
						ds0_n_o      <= 1'b1;
						hnd_state    <= HND_REL;
					end
				end
				HND_REL: begin
					// strobe rises only after write and data strobe are released
					if (!write_n_oe && !ds0_n_oe) begin
						as_n_o    <= 1'b1;
						hnd_state <= HND_OFF;
					end
				end
				HND_OFF: begin
					as_n_oe    <= 1'b0;
					bus_wanted <= 1'b0;
					hnd_state  <= HND_IDLE;
				end
				default: begin
					hnd_state <= HND_IDLE;
				end
			endcase
		end
	end

endmodule

// *** core/bia_pkg.sv ***
// shared constants and state types for the bus interrupt acknowledge logic
package bia_pkg;

	// ----------------------------------------
	// bus codes
	// ----------------------------------------
	localparam logic [7:0] BIA_IACK_CODE   = 8'h27;
	localparam logic [2:0] BIA_LEVEL_NONE  = 3'h0;
	localparam logic [7:0] BIA_STATUS_RST  = 8'h00;

	// ----------------------------------------
	// timing
	// ----------------------------------------
	localparam int CLK_PERIOD_NS     = 50;
	localparam int T_DATA_SETUP_NS   = 30;
	localparam int T_IRQ_RELEASE_NS  = 30;
	localparam int T_ADDR_SETUP_NS   = 30;
	localparam int T_ACKOUT_HIGH_NS  = 50;

	localparam int DATA_SETUP_CYC_I  = (T_DATA_SETUP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int IRQ_REL_CYC_I     = (T_IRQ_RELEASE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int ADDR_SETUP_CYC_I  = (T_ADDR_SETUP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int ACKOUT_MAX_CYC_I  = (T_ACKOUT_HIGH_NS / CLK_PERIOD_NS < 1) ? 1 :
	                                   T_ACKOUT_HIGH_NS / CLK_PERIOD_NS;

	localparam logic [2:0] DATA_SETUP_CYC = 3'(DATA_SETUP_CYC_I < 1 ? 1 : DATA_SETUP_CYC_I);
	localparam logic [2:0] IRQ_REL_CYC    = 3'(IRQ_REL_CYC_I < 1 ? 1 : IRQ_REL_CYC_I);
	localparam logic [2:0] ADDR_SETUP_CYC = 3'(ADDR_SETUP_CYC_I < 1 ? 1 : ADDR_SETUP_CYC_I);
	localparam logic [2:0] ACKOUT_MAX_CYC = 3'(ACKOUT_MAX_CYC_I);
	localparam logic [2:0] CNT_ZERO       = 3'h0;
	localparam logic [2:0] CNT_ONE        = 3'h1;

	// ----------------------------------------
	// state types
	// ----------------------------------------
	typedef enum logic [6:0] {
		INT_IDLE = 7'h01,
		INT_PASS = 7'h02,
		INT_REQ  = 7'h04,
		INT_DATA = 7'h08,
		INT_ACK  = 7'h10,
		INT_WAIT = 7'h20,
		INT_DONE = 7'h40
	} bia_int_state_t;

	typedef enum logic [6:0] {
		HND_IDLE  = 7'h01,
		HND_REQ   = 7'h02,
		HND_SETUP = 7'h04,
		HND_ASL   = 7'h08,
		HND_READ  = 7'h10,
		HND_REL   = 7'h20,
		HND_OFF   = 7'h40
	} bia_hnd_state_t;

endpackage

// *** core/bia_prioritizer.sv ***
// handler prioritizer: picks the highest pending unmasked request level
`timescale 1ns/100ps
module bia_prioritizer
	import bia_pkg::*;
(
	input  wire logic       clk,
	input  wire logic       rst_n,
	input  wire logic [7:1] irq_n_i,
	input  wire logic [7:1] level_enable,
	input  wire logic [2:0] mask_level,
	output logic            pending,
	output logic [2:0]      level
);

	// ----------------------------------------
	// selection
	// ----------------------------------------
	function automatic logic [2:0] top_level(input logic [7:1] req);
		logic [2:0] lv;
		lv = BIA_LEVEL_NONE;
		for (int i = 1; i <= 7; i++) begin
			if (req[i]) begin
				lv = 3'(i);
			end
		end
		return lv;
	endfunction

	// a single enabled level is simply its own highest level
	wire logic [7:1] active    = ~irq_n_i & level_enable;
	wire logic [2:0] best      = top_level(active);
	wire logic       above     = (best != BIA_LEVEL_NONE) && (best > mask_level);

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			pending <= 1'b0;
			level   <= BIA_LEVEL_NONE;
		end else begin
			pending <= above;
			level   <= best;
		end
	end

endmodule

// *** dv/bia_top_assertions.sv ***
// concurrent checks on the ports of the interrupt acknowledge top
`timescale 1ns/100ps
module bia_top_assertions
	import bia_pkg::*;
(
	input wire logic       clk,
	input wire logic       resetn,
	input wire logic       irq_wanted,
	input wire logic       bus_irq_acked,
	input wire logic [2:0] irq_level,
	input wire logic [7:0] status_id,
	input wire logic [2:0] mask_level,
	input wire logic       bus_wanted,
	input wire logic [2:0] ack_level,
	input wire logic [7:1] irq_n_oe,
	input wire logic       ackin_n,
	input wire logic       ackout_n,
	input wire logic       as_n_i,
	input wire logic       as_n_o,
	input wire logic       as_n_oe,
	input wire logic [7:0] am_n_o,
	input wire logic       am_n_oe,
	input wire logic [2:0] addr_n_o,
	input wire logic       ds0_n_o,
	input wire logic       ds0_n_oe,
	input wire logic       write_n_o,
	input wire logic       write_n_oe,
	input wire logic [7:0] data_n_o,
	input wire logic       data_n_oe,
	input wire logic       dtack_n_oe
);
	default clocking cb @(posedge clk); endclocking
	default disable iff (!resetn);
	// ----------------------------------------
	// interrupter
	// ----------------------------------------
	sequence s_ack_start;
		$rose(dtack_n_oe);
	endsequence
	a_irq_raise: assert property ($rose(irq_wanted) && ackin_n |-> ##[1:4] irq_n_oe[irq_level])
		else $error("request line not driven");
	a_data_setup: assert property (s_ack_start |-> $past(data_n_oe) && data_n_o == ~status_id)
		else $error("status byte not valid before acknowledge");
	a_irq_release: assert property (s_ack_start |-> ##[0:3] irq_n_oe == 7'h00)
		else $error("request line not released");
	a_acked_rise: assert property (s_ack_start ##0 irq_wanted |-> ##[1:2] bus_irq_acked)
		else $error("acked not raised");
	a_dtack_drop: assert property ($fell(dtack_n_oe) |-> as_n_i && !data_n_oe && !$past(data_n_oe))
		else $error("acknowledge released early");
	a_acked_drop: assert property (bus_irq_acked && !dtack_n_oe && !irq_wanted |-> ##[1:2] !bus_irq_acked)
		else $error("acked not dropped");
	a_no_pass: assert property (data_n_oe |-> ackout_n)
		else $error("daisy passed while answering");
	a_daisy_high: assert property (!ackout_n && as_n_i |=> ackout_n)
		else $error("daisy output not high in time");
	// ----------------------------------------
	// handler
	// ----------------------------------------
	a_mask_level: assert property ($rose(bus_wanted) |-> ack_level > mask_level)
		else $error("bus wanted at masked level");
	a_addr_setup: assert property ($fell(as_n_o) && as_n_oe |-> $past(am_n_oe) && $stable(am_n_o) &&
		am_n_o == ~BIA_IACK_CODE && addr_n_o == ~ack_level)
		else $error("address not set up before strobe");
	a_read_write: assert property (ds0_n_oe && !ds0_n_o |-> write_n_oe && write_n_o)
		else $error("data strobe without read");
	a_strobe_hold: assert property (as_n_oe && !as_n_o && (ds0_n_oe || write_n_oe) |=> !as_n_o)
		else $error("strobe released before data lines");
endmodule
bind bia_top bia_top_assertions u_chk (.*);

// *** dv/bia_remote_intr.sv ***
// behavioural interrupter on the far side of the backplane
`timescale 1ns/100ps
module bia_remote_intr
	import bia_pkg::*;
(
	input  wire logic       clk,
	input  wire logic       resetn,
	input  wire logic       req,
	input  wire logic [2:0] level,
	input  wire logic [7:0] id,
	input  wire logic       as_n,
	input  wire logic [7:0] am_n,
	input  wire logic [2:0] addr_n,
	input  wire logic       ds0_n,
	input  wire logic       ackin_n,
	output logic            irq_oe,
	output logic            data_oe,
	output logic [7:0]      data_o,
	output logic            dtack_oe
);
	logic served;
	wire  hit = !as_n && am_n == ~BIA_IACK_CODE && addr_n == ~level && !ackin_n && irq_oe;
	assign data_o = ~id;
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			{irq_oe, data_oe, dtack_oe, served} <= 4'h0;
		end else begin
			if (dtack_oe) irq_oe <= 1'b0;
			else if (req && !served) irq_oe <= 1'b1;
			if (dtack_oe) served <= 1'b1;
			else if (!req) served <= 1'b0;
			if (hit && !ds0_n) data_oe <= 1'b1;
			else if (as_n) data_oe <= 1'b0;
			if (data_oe && !as_n) dtack_oe <= 1'b1;
			else if (as_n && !data_oe) dtack_oe <= 1'b0;
		end
	end
endmodule

// *** dv/tb_bia_top.sv ***
// self-checking bench for the interrupt acknowledge top
`timescale 1ns/100ps
module tb_bia_top
	import bia_pkg::*;
;
	logic clk, resetn, irq_wanted, bus_granted, p_req, passed;
	logic [2:0] irq_level, mask_level, p_lvl, got_lvl;
	logic [7:0] status_id, p_id, got, data_w, p_data;
	logic [7:1] level_enable;
	int compares, miscompares, nvalid, n, nerr;
	wire bus_irq_acked, bus_wanted, status_valid, status_error, ackout_n, as_n_o, as_n_oe;
	wire am_n_oe, addr_n_oe, ds0_n_o, ds0_n_oe, write_n_o, write_n_oe, data_n_oe, dtack_n_o;
	wire dtack_n_oe, p_irq_oe, p_data_oe, p_dtack_oe;
	wire [2:0] ack_level, addr_n_o;
	wire [7:0] status_read, am_n_o, data_n_o;
	wire [7:1] irq_n_o, irq_n_oe;
	// ----------------------------------------
	// backplane wires, pulled up when released
	// ----------------------------------------
	wire [7:1] irq_w = ~(irq_n_oe | (p_irq_oe ? 7'(1 << (p_lvl - 1)) : 7'h00));
	wire       as_w = as_n_oe ? as_n_o : 1'b1;
	wire [7:0] am_w = am_n_oe ? am_n_o : 8'hff;
	wire [2:0] addr_w = addr_n_oe ? addr_n_o : 3'h7;
	wire       ds0_w = ds0_n_oe ? ds0_n_o : 1'b1;
	wire       dtack_w = !(dtack_n_oe | p_dtack_oe);
	assign data_w = data_n_oe ? data_n_o : (p_data_oe ? p_data : 8'hff);
	bia_top DUT (.clk(clk), .resetn(resetn), .irq_wanted(irq_wanted), .bus_irq_acked(bus_irq_acked),
		.irq_level(irq_level), .status_id(status_id), .level_enable(level_enable),
		.mask_level(mask_level), .bus_wanted(bus_wanted), .bus_granted(bus_granted),
		.ack_level(ack_level), .status_read(status_read), .status_valid(status_valid),
		.status_error(status_error), .irq_n_i(irq_w), .irq_n_o(irq_n_o), .irq_n_oe(irq_n_oe),
		.ackin_n(am_w[5]), .ackout_n(ackout_n), .as_n_i(as_w), .as_n_o(as_n_o), .as_n_oe(as_n_oe),
		.am_n_i(am_w), .am_n_o(am_n_o), .am_n_oe(am_n_oe), .addr_n_i(addr_w),
		.addr_n_o(addr_n_o), .addr_n_oe(addr_n_oe), .ds0_n_i(ds0_w), .ds0_n_o(ds0_n_o),
		.ds0_n_oe(ds0_n_oe), .write_n_o(write_n_o), .write_n_oe(write_n_oe), .data_n_i(data_w),
		.data_n_o(data_n_o), .data_n_oe(data_n_oe), .dtack_n_i(dtack_w), .dtack_n_o(dtack_n_o),
		.dtack_n_oe(dtack_n_oe), .berr_n_i(1'b1));
	// far interrupter sits downstream of the design's daisy output
	bia_remote_intr u_far (.clk(clk), .resetn(resetn), .req(p_req), .level(p_lvl), .id(p_id),
		.as_n(as_w), .am_n(am_w), .addr_n(addr_w), .ds0_n(ds0_w), .ackin_n(ackout_n),
		.irq_oe(p_irq_oe), .data_oe(p_data_oe), .data_o(p_data), .dtack_oe(p_dtack_oe));
	initial begin
		clk = 1'b0;
		forever #25 clk = ~clk;
	end
	// valid pulses last one cycle, so they are caught here
	always @(posedge clk) begin
		bus_granted <= bus_wanted;
		if (ackout_n === 1'b0) passed <= 1'b1;
		if (status_error === 1'b1) nerr <= nerr + 1;
		if (status_valid === 1'b1) begin
			got <= status_read;
			got_lvl <= ack_level;
			nvalid <= nvalid + 1;
		end
	end
	// ----------------------------------------
	// helpers
	// ----------------------------------------
	task check(input logic [7:0] seen, input logic [7:0] exp);
		compares++;
		if (seen !== exp) begin
			miscompares++;
			$display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask
	task report_and_stop;
		$display("compares=%0d miscompares=%0d", compares, miscompares);
		if (miscompares == 0 && compares > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask
	task wait_acked(input logic v);
		int i;
		for (i = 0; i < 400 && bus_irq_acked !== v; i++) @(negedge clk);
		if (i == 400) miscompares++;
	endtask
	task wait_valid(input int k);
		int i;
		for (i = 0; i < 400 && nvalid < k; i++) @(negedge clk);
		if (i == 400) miscompares++;
	endtask
	// own request, device side keeps the want/acked handshake
	task serve(input logic [2:0] lvl, input logic [7:0] id);
		int k;
		k = nvalid;
		@(posedge clk) {irq_level, status_id, irq_wanted} <= {lvl, id, 1'b1};
		passed <= 1'b0;
		wait_acked(1'b1);
		check(passed, 1'b0);
		@(posedge clk) irq_wanted <= 1'b0;
		wait_acked(1'b0);
		wait_valid(k + 1);
		check(got, id);
		check(got_lvl, lvl);
		repeat (3) @(negedge clk);
		check({1'b0, irq_n_oe}, 8'h00);
	endtask
	// ----------------------------------------
	// scenarios
	// ----------------------------------------
	task t_levels;
		logic [3:0] l;
		for (l = 1; l <= 7; l++) begin
			n = nvalid;
			serve(l[2:0], {l[2:0], 5'h0a});
			check(8'(nvalid), 8'(n + 1));
		end
	endtask
	task t_prio;
		@(posedge clk) {p_lvl, p_id, passed} <= {3'h2, 8'ha5, 1'b0};
		// far request starts a cycle late so both lines are low when the level is picked
		fork
			serve(3'h7, 8'h5c);
			begin
				repeat (2) @(posedge clk);
				p_req <= 1'b1;
			end
		join
		wait_valid(nvalid + 1);
		check(got, 8'ha5);
		check(got_lvl, 3'h2);
		check(passed, 1'b1);
		@(posedge clk) p_req <= 1'b0;
	endtask
	task t_mask;
		@(posedge clk) {mask_level, irq_level, irq_wanted} <= {3'h5, 3'h4, 1'b1};
		repeat (30) @(negedge clk);
		check(bus_wanted, 1'b0);
		@(posedge clk) mask_level <= 3'h3;
		serve(3'h4, 8'hc3);
		check(8'(nerr), 8'h00);
	endtask
	initial begin
		{resetn, irq_wanted, p_req, passed, mask_level, irq_level, p_lvl} = 13'h0;
		{status_id, p_id, bus_granted, nvalid, compares, miscompares, nerr} = 0;
		level_enable = 7'h7f;
		repeat (20) @(posedge clk);
		resetn <= 1'b1;
		repeat (5) @(posedge clk);
		t_levels;
		t_prio;
		t_mask;
		report_and_stop;
	end
	initial begin
		#(50 * 40000);
		miscompares++;
		report_and_stop;
	end
endmodule
